// ---- hw/dag_defines.svh ----
// Contract
// [RULE1] Inherent instructions carry no operand and start no data access.
// [RULE2] Literal instructions use opcode immediate; long branches carry 20-bit targets.
// [RULE3] Bit and byte instructions address directly via opcode low byte.
// [RULE4] Access bit one joins bank select with file address into 12 bits.
// [RULE5] Access bit zero maps file address into access bank, bank ignored.
// [RULE6] Register-to-register move uses its full 12-bit addresses, bank ignored.
// [RULE7] Destination bit one writes file, zero writes working register.
// [RULE8] Three pointer pairs, each a 12-bit linear data address.
// [RULE9] Each pair has virtual operands that access memory at its pointer.
// [RULE10] Indirect targets come only from the pointer, never bank or access.
// [RULE11] Post operands use pointer then step; pre-increment steps first. Code uses the unstepped pointer for a separate move destination.
// [RULE12] Offset operand adds signed working register; nothing is modified. Code omits the offset for a separate move destination.
// [RULE13] Plain indirect operand leaves its pointer unchanged.
// [RULE14] Steps act on all twelve bits, carrying across the low byte.
// [RULE15] Pointer steps never touch arithmetic status flags.
// [RULE16] Indirect read of a virtual operand returns zero.
// [RULE17] Indirect write to a virtual operand does nothing.
// [RULE18] Writing a pair through its own operand stores value without step.
// [RULE19] Pointers reachable directly; indirect reaches all other registers.
// [RULE20] Extended set enabled accepts five extra two-word instructions.
// [RULE21] Extended set leaves program memory targets unchanged.
// [RULE22] Extended set: access operand at or below 5Fh offsets third pointer.
// [RULE23] Pointer steps commit with the access so next instruction sees them. Code drops a step when a byte write hits the same pair that cycle.
`ifndef DAG_DEFINES_SVH
`define DAG_DEFINES_SVH
// Opcode fields
`define DAG_F_LSB       0
`define DAG_F_MSB       7
`define DAG_A_BIT       8
`define DAG_D_BIT       9
// Access bank layout
`define DAG_ACC_SPLIT   8'h60
`define DAG_IDX_LAST    8'h5f
`define DAG_ACC_HI_BANK 4'hf
`define DAG_ACC_LO_BANK 4'h0
// Low byte address of each pointer pair; operands sit above it
`define DAG_P0_BASE     12'hfe9
`define DAG_P1_BASE     12'hfe1
`define DAG_P2_BASE     12'hfd9
`define DAG_OFS_LO      3'h0
`define DAG_OFS_HI      3'h1
`define DAG_OFS_WORKING_OFFSET_OPERAND   3'h2
`define DAG_OFS_BEFORE_ACCESS_INCREMENT_OPERAND  3'h3
`define DAG_OFS_AFTER_ACCESS_DECREMENT_OPERAND 3'h4
`define DAG_OFS_AFTER_ACCESS_INCREMENT_OPERAND 3'h5
`define DAG_OFS_PLAIN   3'h6
// Reset values
`define DAG_PTR_RST     12'h000
`endif

// ---- hw/dag_pkg.sv ----
package dag_pkg;
   // Instruction classes from the decoder
   typedef enum logic [2:0] {
      CLS_INHERENT, CLS_LITERAL, CLS_BYTE, CLS_BIT, CLS_MOVE_FF, CLS_BRANCH, CLS_EXT
   } dag_class_t;
   // Virtual operand kinds
   typedef enum logic [2:0] {
      VOP_NONE, VOP_PLAIN, VOP_AFTER_ACCESS_INCREMENT_OPERAND, VOP_AFTER_ACCESS_DECREMENT_OPERAND, VOP_BEFORE_ACCESS_INCREMENT_OPERAND, VOP_WORKING_OFFSET_OPERAND
   } dag_vop_t;
   // Extended two-word instructions
   typedef enum logic [2:0] {
      EXT_PTR_ADD, EXT_PTR_SUB, EXT_CALL_W, EXT_STK_TO_FILE, EXT_STK_TO_STK
   } dag_ext_t;
endpackage

// ---- hw/dag_addr_map.sv ----
`timescale 1ns/1ps
`include "dag_defines.svh"
module dag_addr_map
   import dag_pkg::*;
(
   // Address under test
   input  wire logic [11:0] addr_i,
   // Decode result
   output logic             ptr_byte_o,
   output logic             ptr_high_o,
   output logic [1:0]       pair_o,
   output dag_vop_t         vop_o
);
   logic [11:0] ofs;
   // Find the pair whose block holds the address, then the slot in it
   always_comb begin
      pair_o     = 2'd3;
      ofs        = 12'h000;
      ptr_byte_o = 1'b0;
      ptr_high_o = 1'b0;
      vop_o      = VOP_NONE;
      if (addr_i >= `DAG_P0_BASE && addr_i <= `DAG_P0_BASE + 12'h006) begin
         pair_o = 2'd0;
         ofs    = addr_i - `DAG_P0_BASE;
      end else if (addr_i >= `DAG_P1_BASE && addr_i <= `DAG_P1_BASE + 12'h006) begin
         pair_o = 2'd1;
         ofs    = addr_i - `DAG_P1_BASE;
      end else if (addr_i >= `DAG_P2_BASE && addr_i <= `DAG_P2_BASE + 12'h006) begin
         pair_o = 2'd2;
         ofs    = addr_i - `DAG_P2_BASE;
      end
      if (pair_o != 2'd3) begin
         case (ofs[2:0])
            `DAG_OFS_LO:      ptr_byte_o = 1'b1;
            `DAG_OFS_HI: begin
               ptr_byte_o = 1'b1;
               ptr_high_o = 1'b1;
            end
            `DAG_OFS_WORKING_OFFSET_OPERAND:   vop_o = VOP_WORKING_OFFSET_OPERAND;
            `DAG_OFS_BEFORE_ACCESS_INCREMENT_OPERAND:  vop_o = VOP_BEFORE_ACCESS_INCREMENT_OPERAND;
            `DAG_OFS_AFTER_ACCESS_DECREMENT_OPERAND: vop_o = VOP_AFTER_ACCESS_DECREMENT_OPERAND;
            `DAG_OFS_AFTER_ACCESS_INCREMENT_OPERAND: vop_o = VOP_AFTER_ACCESS_INCREMENT_OPERAND;
            default:          vop_o = VOP_PLAIN;
         endcase
      end
   end
endmodule // dag_addr_map

// ---- hw/dag_ptr_file.sv ----
`timescale 1ns/1ps
`include "dag_defines.svh"
module dag_ptr_file (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   // Whole-pointer update
   input  wire logic        step_en_i,
   input  wire logic [1:0]  step_sel_i,
   input  wire logic [11:0] step_val_i,
   // Byte write
   input  wire logic        byte_en_i,
   input  wire logic [1:0]  byte_sel_i,
   input  wire logic        byte_high_i,
   input  wire logic [7:0]  byte_data_i,
   // Pointer values
   output logic [11:0]      ptr0_o,
   output logic [11:0]      ptr1_o,
   output logic [11:0]      ptr2_o
);
   logic [11:0] ptr_reg [3];
   // Byte write wins over a step on the same pair; high nibble unused
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < 3; i++) begin
            ptr_reg[i] <= `DAG_PTR_RST;
         end
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (byte_en_i && byte_sel_i == 2'(i)) begin
               if (byte_high_i) begin
                  ptr_reg[i][11:8] <= byte_data_i[3:0]; // see [RULE8]
               end else begin
                  ptr_reg[i][7:0] <= byte_data_i;
               end
            end else if (step_en_i && step_sel_i == 2'(i)) begin
               ptr_reg[i] <= step_val_i; // see [RULE23]
            end
         end
      end
   end
   assign ptr0_o = ptr_reg[0];
   assign ptr1_o = ptr_reg[1];
   assign ptr2_o = ptr_reg[2];
endmodule // dag_ptr_file

// ---- hw/dag_top.sv ----
`timescale 1ns/1ps
`include "dag_defines.svh"
module dag_top
   import dag_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   // Instruction from decoder
   input  wire logic        op_valid_i,
   input  wire dag_class_t  op_class_i,
   input  wire dag_ext_t    op_ext_i,
   input  wire logic        op_wr_file_i,
   input  wire logic [15:0] opcode_i,
   input  wire logic [15:0] opword2_i,
   // Core state
   input  wire logic [7:0]  wreg_i,
   input  wire logic [3:0]  bank_select_register_i,
   input  wire logic        extended_set_enable_i,
   // Result from execution unit
   input  wire logic        wr_en_i,
   input  wire logic [7:0]  wr_data_i,
   // Data memory read data
   input  wire logic [7:0]  mem_rdata_i,
   // Data memory access
   output logic [11:0]      mem_addr_o,
   output logic             mem_rd_o,
   output logic [11:0]      mem_waddr_o,
   output logic [7:0]       mem_wdata_o,
   output logic             mem_wr_o,
   // Operand to execution unit
   output logic [7:0]       rd_data_o,
   output logic             rd_valid_o,
   output logic             dest_w_o,
   output logic [7:0]       literal_o,
   output logic [19:0]      target_o,
   output logic             target_valid_o,
   output logic             illegal_o,
   // Pointer values
   output logic [11:0]      ptr0_o,
   output logic [11:0]      ptr1_o,
   output logic [11:0]      ptr2_o
);
   // Direct address from file field, access bit and extended mode
   function automatic logic [11:0] dir_addr(input logic [7:0] f, input logic a,
                                             input logic [3:0] bank_select_register, input logic ext,
                                             input logic [11:0] p2);
      if (a) begin
         dir_addr = {bank_select_register, f}; // see [RULE4]
      end else if (ext && f <= `DAG_IDX_LAST) begin
         dir_addr = p2 + {4'h0, f}; // see [RULE22]
      end else if (f < `DAG_ACC_SPLIT) begin
         dir_addr = {`DAG_ACC_LO_BANK, f}; // see [RULE5]
      end else begin
         dir_addr = {`DAG_ACC_HI_BANK, f};
      end
   endfunction

   logic [11:0] ptr_q [3];
   logic [11:0] src_raw, dst_raw, src_eff, dst_eff, base_ptr, step_val;
   logic        step_en, reads_file, writes_file, dest_w, is_illegal;
   logic [1:0]  step_sel;
   logic [7:0]  f_fld;
   // Decode outputs
   logic        s_pb, s_ph, t_pb, t_ph, d_pb, d_ph, e_pb, e_ph;
   logic [1:0]  s_pair, t_pair, d_pair, e_pair;
   dag_vop_t    s_vop, t_vop, d_vop, e_vop;
   // Held access state
   logic        rd_pend_reg, rd_null_reg, rd_ptr_reg, rd_ptr_hi_reg;
   logic [1:0]  rd_pair_reg;
   logic        wr_arm_reg, wr_null_reg, wr_ptr_reg, wr_ptr_hi_reg;
   logic [1:0]  wr_pair_reg;
   logic [11:0] wr_addr_reg;
   logic        byte_en;

   assign ptr_q[0] = ptr0_o;
   assign ptr_q[1] = ptr1_o;
   assign ptr_q[2] = ptr2_o;
   assign f_fld    = opcode_i[`DAG_F_MSB:`DAG_F_LSB]; // see [RULE3]

   // Raw source and destination per class
   always_comb begin
      src_raw     = dir_addr(f_fld, opcode_i[`DAG_A_BIT], bank_select_register_i,
                             extended_set_enable_i, ptr_q[2]);
      dst_raw     = src_raw;
      reads_file  = 1'b0;
      writes_file = 1'b0;
      dest_w      = 1'b0;
      is_illegal  = 1'b0;
      case (op_class_i)
         CLS_INHERENT: begin
            reads_file = 1'b0; // see [RULE1]
         end
         CLS_LITERAL: begin
            dest_w = 1'b1; // see [RULE2]
         end
         CLS_BYTE: begin
            reads_file  = 1'b1;
            writes_file = opcode_i[`DAG_D_BIT]; // see [RULE7]
            dest_w      = !opcode_i[`DAG_D_BIT];
         end
         CLS_BIT: begin
            reads_file  = 1'b1;
            writes_file = op_wr_file_i;
         end
         CLS_MOVE_FF: begin
            src_raw     = opcode_i[11:0]; // see [RULE6]
            dst_raw     = opword2_i[11:0];
            reads_file  = 1'b1;
            writes_file = 1'b1;
         end
         CLS_EXT: begin
            is_illegal = !extended_set_enable_i; // see [RULE20]
            if (op_ext_i == EXT_STK_TO_FILE || op_ext_i == EXT_STK_TO_STK) begin
               src_raw     = ptr_q[2] + {5'h00, opcode_i[6:0]};
               dst_raw     = (op_ext_i == EXT_STK_TO_FILE) ? opword2_i[11:0]
                                                          : ptr_q[2] + {5'h00, opword2_i[6:0]};
               reads_file  = extended_set_enable_i;
               writes_file = extended_set_enable_i;
            end
         end
         default: begin
            reads_file = 1'b0;
         end
      endcase
   end

   // Operand decode of source, indirect target, destination and its target
   dag_addr_map u_map_src (
      .addr_i    (src_raw),
      .ptr_byte_o(s_pb),
      .ptr_high_o(s_ph),
      .pair_o    (s_pair),
      .vop_o     (s_vop)
   );
   dag_addr_map u_map_tgt (
      .addr_i    (src_eff),
      .ptr_byte_o(t_pb),
      .ptr_high_o(t_ph),
      .pair_o    (t_pair),
      .vop_o     (t_vop)
   );
   dag_addr_map u_map_dst (
      .addr_i    (dst_raw),
      .ptr_byte_o(d_pb),
      .ptr_high_o(d_ph),
      .pair_o    (d_pair),
      .vop_o     (d_vop)
   );
   dag_addr_map u_map_dtg (
      .addr_i    (dst_eff),
      .ptr_byte_o(e_pb),
      .ptr_high_o(e_ph),
      .pair_o    (e_pair),
      .vop_o     (e_vop)
   );

   // Indirect resolution from pointer only; steps act on all 12 bits
   always_comb begin
      base_ptr = (s_pair == 2'd3) ? 12'h000 : ptr_q[s_pair];
      src_eff  = src_raw;
      step_en  = 1'b0;
      step_sel = s_pair;
      step_val = base_ptr;
      case (s_vop)
         VOP_PLAIN:   src_eff = base_ptr; // see [RULE9] [RULE10] [RULE13]
         VOP_AFTER_ACCESS_INCREMENT_OPERAND: begin
            src_eff  = base_ptr; // see [RULE11]
            step_en  = 1'b1;
            step_val = base_ptr + 12'h001; // see [RULE14] [RULE15]
         end
         VOP_AFTER_ACCESS_DECREMENT_OPERAND: begin
            src_eff  = base_ptr;
            step_en  = 1'b1;
            step_val = base_ptr - 12'h001; // see [RULE14]
         end
         VOP_BEFORE_ACCESS_INCREMENT_OPERAND: begin
            src_eff  = base_ptr + 12'h001; // see [RULE11]
            step_en  = 1'b1;
            step_val = base_ptr + 12'h001;
         end
         VOP_WORKING_OFFSET_OPERAND:   src_eff = base_ptr + {{4{wreg_i[7]}}, wreg_i}; // see [RULE12]
         default:     src_eff = src_raw;
      endcase
      // A write into the stepping pair's own bytes stores the value unstepped
      if (writes_file && t_pb && t_pair == s_pair && dst_raw == src_raw) begin
         step_en = 1'b0; // see [RULE18]
      end
      if (!op_valid_i || !(reads_file || writes_file)) begin
         step_en = 1'b0;
      end
      // Extended pointer add and subtract
      if (op_valid_i && op_class_i == CLS_EXT && extended_set_enable_i &&
          (op_ext_i == EXT_PTR_ADD || op_ext_i == EXT_PTR_SUB) && opcode_i[7:6] != 2'd3) begin
         step_en  = 1'b1;
         step_sel = opcode_i[7:6];
         step_val = (op_ext_i == EXT_PTR_ADD) ? ptr_q[opcode_i[7:6]] + {6'h00, opcode_i[5:0]}
                                              : ptr_q[opcode_i[7:6]] - {6'h00, opcode_i[5:0]};
      end
   end

   // Destination of a separate move resolves without stepping
   always_comb begin
      dst_eff = (dst_raw == src_raw) ? src_eff : dst_raw;
      if (dst_raw != src_raw && d_vop != VOP_NONE && d_pair != 2'd3) begin
         dst_eff = ptr_q[d_pair];
      end
   end

   // Address phase: read strobe and held read-target decode
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mem_addr_o    <= 12'h000;
         mem_rd_o      <= 1'b0;
         rd_null_reg   <= 1'b0;
         rd_ptr_reg    <= 1'b0;
         rd_ptr_hi_reg <= 1'b0;
         rd_pair_reg   <= 2'd0;
      end else begin
         mem_rd_o <= 1'b0;
         if (op_valid_i && reads_file) begin
            mem_addr_o    <= src_eff;
            mem_rd_o      <= !(s_vop != VOP_NONE && t_vop != VOP_NONE); // see [RULE16]
            rd_null_reg   <= s_vop != VOP_NONE && t_vop != VOP_NONE;
            rd_ptr_reg    <= t_pb; // see [RULE19]
            rd_ptr_hi_reg <= t_ph;
            rd_pair_reg   <= t_pair;
         end
      end
   end

   // Data return: null reads give zero, pointer bytes come from the pair
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rd_pend_reg <= 1'b0;
         rd_valid_o  <= 1'b0;
         rd_data_o   <= 8'h00;
      end else begin
         rd_pend_reg <= op_valid_i && reads_file;
         rd_valid_o  <= rd_pend_reg;
         if (rd_pend_reg) begin
            if (rd_null_reg) begin
               rd_data_o <= 8'h00; // see [RULE16]
            end else if (rd_ptr_reg && rd_pair_reg != 2'd3) begin
               rd_data_o <= rd_ptr_hi_reg ? {4'h0, ptr_q[rd_pair_reg][11:8]}
                                          : ptr_q[rd_pair_reg][7:0];
            end else begin
               rd_data_o <= mem_rdata_i;
            end
         end
      end
   end

   // Held write target for the result
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_arm_reg    <= 1'b0;
         wr_null_reg   <= 1'b0;
         wr_ptr_reg    <= 1'b0;
         wr_ptr_hi_reg <= 1'b0;
         wr_pair_reg   <= 2'd0;
         wr_addr_reg   <= 12'h000;
      end else if (op_valid_i) begin
         wr_arm_reg    <= writes_file;
         wr_null_reg   <= (d_vop != VOP_NONE || s_vop != VOP_NONE) && e_vop != VOP_NONE;
         wr_ptr_reg    <= e_pb;
         wr_ptr_hi_reg <= e_ph;
         wr_pair_reg   <= e_pair;
         wr_addr_reg   <= dst_eff;
      end else if (wr_en_i) begin
         wr_arm_reg <= 1'b0;
      end
   end

   // Result write: null targets drop, pointer bytes go to the pair
   assign byte_en = wr_en_i && wr_arm_reg && !wr_null_reg && wr_ptr_reg;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mem_wr_o    <= 1'b0;
         mem_waddr_o <= 12'h000;
         mem_wdata_o <= 8'h00;
      end else begin
         mem_wr_o <= wr_en_i && wr_arm_reg && !wr_null_reg && !wr_ptr_reg; // see [RULE17]
         if (wr_en_i && wr_arm_reg) begin
            mem_waddr_o <= wr_addr_reg;
            mem_wdata_o <= wr_data_i;
         end
      end
   end

   dag_ptr_file u_ptrs (
      .clk_i      (clk_i),
      .rstn_i     (rstn_i),
      .step_en_i  (step_en),
      .step_sel_i (step_sel),
      .step_val_i (step_val),
      .byte_en_i  (byte_en),
      .byte_sel_i (wr_pair_reg),
      .byte_high_i(wr_ptr_hi_reg),
      .byte_data_i(wr_data_i),
      .ptr0_o     (ptr0_o),
      .ptr1_o     (ptr1_o),
      .ptr2_o     (ptr2_o)
   );

   // Literal, branch target, destination and acceptance
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         literal_o      <= 8'h00;
         target_o       <= 20'h00000;
         target_valid_o <= 1'b0;
         dest_w_o       <= 1'b0;
         illegal_o      <= 1'b0;
      end else begin
         target_valid_o <= op_valid_i && op_class_i == CLS_BRANCH;
         illegal_o      <= op_valid_i && is_illegal;
         if (op_valid_i) begin
            literal_o <= f_fld; // see [RULE2]
            dest_w_o  <= dest_w; // see [RULE7]
            target_o  <= {opword2_i[11:0], f_fld}; // see [RULE21]
         end
      end
   end

   a_inherent_idle: assert property (@(posedge clk_i) disable iff (!rstn_i) // see [RULE1]
      op_valid_i && op_class_i == CLS_INHERENT |=> !mem_rd_o)
      else $error("inherent op started an access");
   a_banked_addr: assert property (@(posedge clk_i) disable iff (!rstn_i) // see [RULE4]
      op_valid_i && op_class_i == CLS_BYTE && opcode_i[8] && s_vop == VOP_NONE
      |=> mem_addr_o == {$past(bank_select_register_i), $past(opcode_i[7:0])})
      else $error("banked address wrong");
   a_access_high: assert property (@(posedge clk_i) disable iff (!rstn_i) // see [RULE5]
      op_valid_i && op_class_i == CLS_BIT && !opcode_i[8] && opcode_i[7:0] >= 8'h60
      && s_vop == VOP_NONE |=> mem_addr_o[11:8] == 4'hf)
      else $error("access bank high mapping wrong");
   a_move_addr: assert property (@(posedge clk_i) disable iff (!rstn_i) // see [RULE6]
      op_valid_i && op_class_i == CLS_MOVE_FF && s_vop == VOP_NONE
      |=> mem_addr_o == $past(opcode_i[11:0]))
      else $error("move source address wrong");
   a_after_access_increment_operand_step: assert property (@(posedge clk_i) disable iff (!rstn_i) // see [RULE11]
      op_valid_i && op_class_i == CLS_BYTE && s_vop == VOP_AFTER_ACCESS_INCREMENT_OPERAND && s_pair == 2'd0
      && !writes_file |=> ptr0_o == $past(ptr0_o) + 12'h001 && mem_addr_o == $past(ptr0_o))
      else $error("post-increment wrong");
   a_working_offset_operand_keeps: assert property (@(posedge clk_i) disable iff (!rstn_i) // see [RULE12]
      op_valid_i && op_class_i == CLS_BYTE && s_vop == VOP_WORKING_OFFSET_OPERAND && s_pair == 2'd0
      && !byte_en |=> $stable(ptr0_o))
      else $error("offset operand moved pointer");
   a_null_read: assert property (@(posedge clk_i) disable iff (!rstn_i) // see [RULE16]
      op_valid_i && reads_file && s_vop != VOP_NONE && t_vop != VOP_NONE
      |=> !mem_rd_o ##1 rd_valid_o && rd_data_o == 8'h00)
      else $error("virtual read not zero");
   a_null_write: assert property (@(posedge clk_i) disable iff (!rstn_i) // see [RULE17]
      wr_en_i && wr_arm_reg && wr_null_reg |=> !mem_wr_o)
      else $error("virtual write reached memory");
   a_ext_reject: assert property (@(posedge clk_i) disable iff (!rstn_i) // see [RULE20]
      op_valid_i && op_class_i == CLS_EXT && !extended_set_enable_i |=> illegal_o)
      else $error("extended op not rejected");
endmodule // dag_top

// ---- tb/dag_mem_model.sv ----
`timescale 1ns/1ps
module dag_mem_model (
   // Clock
   input  wire logic        clk_i,
   // Read side
   input  wire logic [11:0] mem_addr_i,
   input  wire logic        mem_rd_i,
   output logic [7:0]       mem_rdata_o,
   // Write side
   input  wire logic [11:0] mem_waddr_i,
   input  wire logic [7:0]  mem_wdata_i,
   input  wire logic        mem_wr_i
);
   logic [7:0]  mem_reg [4096];
   logic [11:0] addr_reg;
   logic        rd_reg;
   logic [7:0]  junk_reg;
   // Preload a pattern the bench can predict
   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem_reg[i] = 8'(i) ^ {4'(i >> 8), 4'(i >> 8)};
      end
      rd_reg = 1'b0;
      addr_reg = 12'h000;
      junk_reg = 8'h5a;
   end
   // Store writes, remember the last read, churn the idle pattern
   always @(posedge clk_i) begin
      if (mem_wr_i) mem_reg[mem_waddr_i] <= mem_wdata_i;
      rd_reg <= mem_rd_i;
      addr_reg <= mem_addr_i;
      junk_reg <= junk_reg + 8'h3b;
   end
   // Data valid around a read only; otherwise a changing pattern
   assign mem_rdata_o = mem_rd_i ? mem_reg[mem_addr_i] : rd_reg ? mem_reg[addr_reg] : junk_reg;
endmodule // dag_mem_model

// ---- tb/dag_top_tb.sv ----
`timescale 1ns/1ps
module dag_top_tb;
   import dag_pkg::*;
   logic clk_i, rstn_i, op_valid_i, op_wr_file_i, extended_set_enable_i, wr_en_i;
   dag_class_t op_class_i;
   dag_ext_t op_ext_i;
   logic [15:0] opcode_i, opword2_i;
   logic [7:0] wreg_i, wr_data_i, mem_rdata_i, mem_wdata_o, rd_data_o, literal_o;
   logic [3:0] bank_select_register_i;
   logic [11:0] mem_addr_o, mem_waddr_o, ptr0_o, ptr1_o, ptr2_o;
   logic mem_rd_o, mem_wr_o, rd_valid_o, dest_w_o, target_valid_o, illegal_o;
   logic [19:0] target_o;
   logic saw_rd, saw_val, saw_wr, saw_ill, saw_tgt;
   logic [11:0] rd_addr, wr_addr;
   logic [7:0] rd_val, wr_val;
   int num_errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   dag_top uut (.clk_i(clk_i), .rstn_i(rstn_i), .op_valid_i(op_valid_i), .op_class_i(op_class_i),
      .op_ext_i(op_ext_i), .op_wr_file_i(op_wr_file_i), .opcode_i(opcode_i),
      .opword2_i(opword2_i), .wreg_i(wreg_i), .bank_select_register_i(bank_select_register_i),
      .extended_set_enable_i(extended_set_enable_i), .wr_en_i(wr_en_i), .wr_data_i(wr_data_i),
      .mem_rdata_i(mem_rdata_i), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
      .mem_waddr_o(mem_waddr_o), .mem_wdata_o(mem_wdata_o), .mem_wr_o(mem_wr_o),
      .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .dest_w_o(dest_w_o),
      .literal_o(literal_o), .target_o(target_o), .target_valid_o(target_valid_o),
      .illegal_o(illegal_o), .ptr0_o(ptr0_o), .ptr1_o(ptr1_o), .ptr2_o(ptr2_o));
   dag_mem_model mem (.clk_i(clk_i), .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o),
      .mem_rdata_o(mem_rdata_i), .mem_waddr_i(mem_waddr_o), .mem_wdata_i(mem_wdata_o),
      .mem_wr_i(mem_wr_o));
   // Clock
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // Hang guard
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 2000) begin
         num_errors++;
         final_report();
      end
   end
   task automatic final_report();
      if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   function automatic logic [7:0] pat(input logic [11:0] a);
      return a[7:0] ^ {a[11:8], a[11:8]};
   endfunction
   function automatic logic [15:0] bo(input logic d, input logic a, input logic [7:0] f);
      return {6'h00, d, a, f};
   endfunction
   // One instruction, optional result write, then watch the ports
   task automatic run_op(input dag_class_t c, input logic [15:0] op, input logic [15:0] w2,
                         input logic wr, input logic [7:0] wd);
      @(negedge clk_i);
      op_valid_i = 1'b1;
      op_class_i = c;
      opcode_i = op;
      opword2_i = w2;
      {saw_rd, saw_val, saw_wr, saw_ill, saw_tgt} = 5'h00;
      for (int n = 0; n < 5; n++) begin
         @(negedge clk_i);
         op_valid_i = 1'b0;
         wr_en_i = wr && (n == 0);
         wr_data_i = wd;
         if (mem_rd_o === 1'b1) {saw_rd, rd_addr} = {1'b1, mem_addr_o};
         if (rd_valid_o === 1'b1) {saw_val, rd_val} = {1'b1, rd_data_o};
         if (mem_wr_o === 1'b1) {saw_wr, wr_addr, wr_val} = {1'b1, mem_waddr_o, mem_wdata_o};
         if (illegal_o === 1'b1) saw_ill = 1'b1;
         if (target_valid_o === 1'b1) saw_tgt = 1'b1;
      end
   endtask
   // Byte read with expected address and data
   task automatic rd(input logic [15:0] op, input logic [11:0] ea);
      run_op(CLS_BYTE, op, 16'h0000, 1'b0, 8'h00);
      chk("mem_addr", {1'b1, ea}, {saw_rd, rd_addr});
      chk("rd_data", {1'b1, pat(ea)}, {saw_val, rd_val});
   endtask
   // Byte write through the access bank
   task automatic wf(input logic [7:0] f, input logic [7:0] d);
      run_op(CLS_BYTE, bo(1'b1, 1'b0, f), 16'h0000, 1'b1, d);
   endtask
   // Main sequence
   initial begin
      {rstn_i, op_valid_i, op_wr_file_i, extended_set_enable_i, wr_en_i} = 5'h00;
      op_class_i = CLS_INHERENT;
      op_ext_i = EXT_PTR_ADD;
      {opcode_i, opword2_i, wreg_i, wr_data_i} = 48'h0;
      bank_select_register_i = 4'h2;
      repeat (4) @(posedge clk_i);
      @(negedge clk_i) rstn_i = 1'b1;
      rd(bo(1'b0, 1'b1, 8'h10), 12'h210);
      chk("dest_w", 1, dest_w_o);
      rd(bo(1'b1, 1'b0, 8'h10), 12'h010);
      chk("dest_w", 0, dest_w_o);
      rd(bo(1'b1, 1'b0, 8'h80), 12'hf80);
      op_wr_file_i = 1'b1;
      run_op(CLS_BIT, bo(1'b0, 1'b0, 8'h90), 16'h0000, 1'b1, 8'h5a);
      chk("bit_rd", {1'b1, 12'hf90}, {saw_rd, rd_addr});
      chk("bit_wr", {1'b1, 12'hf90}, {saw_wr, wr_addr});
      op_wr_file_i = 1'b0;
      run_op(CLS_MOVE_FF, 16'h0345, 16'h0123, 1'b1, 8'ha5);
      chk("move_rd", {1'b1, 12'h345}, {saw_rd, rd_addr});
      chk("move_wr", {1'b1, 12'h123}, {saw_wr, wr_addr});
      chk("move_dat", 8'ha5, wr_val);
      wf(8'hea, 8'hf1);
      wf(8'he9, 8'hff);
      chk("ptr0", 12'h1ff, ptr0_o);
      rd(bo(1'b0, 1'b0, 8'hee), 12'h1ff);
      rd(bo(1'b0, 1'b0, 8'hef), 12'h200);
      chk("ptr0", 12'h200, ptr0_o);
      rd(bo(1'b0, 1'b0, 8'hed), 12'h200);
      chk("ptr0", 12'h1ff, ptr0_o);
      rd(bo(1'b0, 1'b0, 8'hec), 12'h200);
      wreg_i = 8'h80;
      rd(bo(1'b0, 1'b0, 8'heb), 12'h180);
      wreg_i = 8'h7f;
      rd(bo(1'b0, 1'b0, 8'heb), 12'h27f);
      chk("ptr0", 12'h200, ptr0_o);
      bank_select_register_i = 4'hf;
      rd(bo(1'b0, 1'b1, 8'hef), 12'h200);
      wf(8'hea, 8'h0f);
      wf(8'he9, 8'he7);
      run_op(CLS_BYTE, bo(1'b0, 1'b0, 8'hef), 16'h0000, 1'b0, 8'h00);
      chk("virt_rd", 10'h100, {saw_rd, saw_val, rd_val});
      wf(8'hef, 8'h77);
      chk("virt_wr", {1'b0, 12'hfe7}, {saw_wr, ptr0_o});
      wf(8'he9, 8'he9);
      wf(8'hed, 8'h34);
      chk("own_wr", {1'b0, 12'hf34}, {saw_wr, ptr0_o});
      wf(8'hda, 8'h03);
      wf(8'hd9, 8'h00);
      chk("ptr2", 12'h300, ptr2_o);
      extended_set_enable_i = 1'b1;
      rd(bo(1'b0, 1'b0, 8'h05), 12'h305);
      rd(bo(1'b0, 1'b0, 8'h60), 12'hf60);
      for (int k = 0; k < 5; k++) begin
         op_ext_i = dag_ext_t'(k);
         extended_set_enable_i = 1'b1;
         run_op(CLS_EXT, 16'h0000, 16'h0000, 1'b0, 8'h00);
         chk("ext_on", 0, saw_ill);
         extended_set_enable_i = 1'b0;
         run_op(CLS_EXT, 16'h0000, 16'h0000, 1'b0, 8'h00);
         chk("ext_off", 1, saw_ill);
      end
      extended_set_enable_i = 1'b1;
      op_ext_i = EXT_PTR_ADD;
      run_op(CLS_EXT, 16'h0045, 16'h0000, 1'b0, 8'h00);
      chk("ptr1", 12'h005, ptr1_o);
      run_op(CLS_LITERAL, 16'h003c, 16'h0000, 1'b0, 8'h00);
      chk("literal", {1'b0, 8'h3c, 1'b1}, {saw_rd, literal_o, dest_w_o});
      run_op(CLS_BRANCH, 16'h0078, 16'h0abc, 1'b0, 8'h00);
      chk("target", 20'habc78, target_o);
      chk("tgt_vld", 1, saw_tgt);
      run_op(CLS_INHERENT, 16'h0006, 16'h0000, 1'b0, 8'h00);
      chk("inherent", 0, {saw_rd, saw_wr});
      final_report();
   end
endmodule // dag_top_tb
